/* File: rtl/sle_pkg.sv */
// Constants, types and field layout of the status lamp pattern encoder
// Operation
// - Stop alone: yellow lamp steadily on
// - Error state: red lamp steadily on
// - Clean run: green on, red and yellow off
// - Run with warning: red 1 Hz, green on
// - Holding point: red on, green 1 Hz
// - Start-up diagnostics: red 1 Hz, green 2 Hz
// - System or internal error: red and yellow on
// - Card write in progress: red and yellow on
// - Configuration load: yellow blinks 2 Hz
// - Lamp test: green blinks 1 Hz
// - Card access in clean run: green flickers
// - Card access with warning: red 1 Hz, green flickers
// - Card access while stopped: yellow flickers
package sle_pkg;

	// Timing
	localparam int unsigned SYS_CLK_HZ = 200_000_000;
	localparam int unsigned BLINK_SLOW_HZ = 1;
	localparam int unsigned BLINK_FAST_HZ = 2;
	localparam int unsigned FLICKER_HZ = 10;
	localparam int unsigned HALF_SLOW_CYC = SYS_CLK_HZ / (2 * BLINK_SLOW_HZ);
	localparam int unsigned HALF_FAST_CYC = SYS_CLK_HZ / (2 * BLINK_FAST_HZ);
	localparam int unsigned HALF_FLICK_CYC = SYS_CLK_HZ / (2 * FLICKER_HZ);

	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FLAGS = 8'h08;

	// Field positions and reset values
	localparam int CTRL_TEST_BIT = 0;
	localparam logic CTRL_TEST_RST = 1'h0;
	localparam int STATUS_LAMP_LSB = 0;
	localparam int STATUS_PAT_LSB = 8;
	localparam int FLAGS_LSB = 0;

	typedef struct packed {
		logic run;
		logic stop;
		logic err_state;
		logic err_warn;
		logic hold_pt;
		logic diag_start;
		logic cfg_load;
		logic sys_err;
		logic card_write;
		logic card_access;
	} sle_flags_t;

	typedef struct packed {
		logic red;
		logic yellow;
		logic green;
	} sle_lamp_t;

	typedef enum logic [3:0] {
		PAT_OFF,
		PAT_SYS_ERR,
		PAT_CARD_WRITE,
		PAT_DIAG,
		PAT_CFG,
		PAT_TEST,
		PAT_RUN,
		PAT_RUN_CARD,
		PAT_RUN_WARN,
		PAT_RUN_WARN_CARD,
		PAT_HOLD,
		PAT_ERR,
		PAT_STOP_CARD,
		PAT_STOP
	} sle_pat_t;

endpackage

/* File: rtl/sle_sync.sv */
// Two-stage synchroniser for asynchronous condition flags
`timescale 1ns/1ps
module sle_sync import sle_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	if (W < 1) begin : g_chk
		$error("sle_sync: W must be at least 1");
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

/* File: rtl/sle_prescaler.sv */
// Square-wave prescaler with 50 percent duty cycle
`timescale 1ns/1ps
module sle_prescaler import sle_pkg::*; #(
	parameter int unsigned HALF_CYC = HALF_SLOW_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Wave out
	output logic wave
);
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] count_reg;
	logic wave_reg;
	wire logic at_last = (count_reg == LAST);

	if (HALF_CYC < 1) begin : g_chk
		$error("sle_prescaler: HALF_CYC must be at least 1");
	end

	// Equal high and low halves; restarts low on reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			wave_reg <= 1'b0;
		end else begin
			count_reg <= at_last ? '0 : count_reg + 1'b1;
			wave_reg <= at_last ? ~wave_reg : wave_reg;
		end
	end

	assign wave = wave_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	wave_toggle_a: assert property (at_last |=> wave_reg != $past(wave_reg))
		else $error("prescaler wave did not toggle at terminal count");
	wave_hold_a: assert property (!at_last |=> wave_reg == $past(wave_reg))
		else $error("prescaler wave toggled early");
endmodule

/* File: rtl/sle_encoder.sv */
// Status lamp pattern encoder with classic Wishbone register slave
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module sle_encoder import sle_pkg::*; #(
	parameter int unsigned HALF_SLOW = HALF_SLOW_CYC,
	parameter int unsigned HALF_FAST = HALF_FAST_CYC,
	parameter int unsigned HALF_FLICK = HALF_FLICK_CYC,
	parameter int GREEN_W = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Condition flags from the core, asynchronous
	input wire sle_flags_t core_flags,
	// Lamps
	output logic lamp_red,
	output logic lamp_yellow,
	output logic [GREEN_W-1:0] lamp_green,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack
);
	if (GREEN_W < 1) begin : g_chk
		$error("sle_encoder: GREEN_W must be at least 1");
	end

	// Synchronised conditions
	sle_flags_t f;
	logic [$bits(sle_flags_t)-1:0] f_bits;

	sle_sync #(
		.W($bits(sle_flags_t))
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d(core_flags),
		.q(f_bits)
	);
	assign f = sle_flags_t'(f_bits);

	// Blink and flicker sources
	logic blink_slow;
	logic blink_fast;
	logic flick;

	sle_prescaler #(
		.HALF_CYC(HALF_SLOW)
	) u_slow (
		.clk_sys(clk_sys),
		.rst(rst),
		.wave(blink_slow)
	);

	sle_prescaler #(
		.HALF_CYC(HALF_FAST)
	) u_fast (
		.clk_sys(clk_sys),
		.rst(rst),
		.wave(blink_fast)
	);

	sle_prescaler #(
		.HALF_CYC(HALF_FLICK)
	) u_flick (
		.clk_sys(clk_sys),
		.rst(rst),
		.wave(flick)
	);

	// Control register and Wishbone ack and read data registers
	logic test_reg;
	logic ack_reg;
	logic [31:0] dat_reg;

	// Pattern selection in falling priority
	wire logic err_hit = f.sys_err || f.card_write;
	wire logic start_hit = f.diag_start || f.cfg_load || test_reg;
	wire sle_pat_t run_pat = f.err_warn ? (f.card_access ? PAT_RUN_WARN_CARD : PAT_RUN_WARN)
		: (f.card_access ? PAT_RUN_CARD : PAT_RUN);
	wire sle_pat_t idle_pat = (f.stop && f.hold_pt) ? PAT_HOLD
		: f.err_state ? PAT_ERR
		: !f.stop ? PAT_OFF
		: f.card_access ? PAT_STOP_CARD : PAT_STOP;
	wire sle_pat_t err_pat = f.sys_err ? PAT_SYS_ERR : PAT_CARD_WRITE;
	wire sle_pat_t start_pat = f.diag_start ? PAT_DIAG : f.cfg_load ? PAT_CFG : PAT_TEST;
	wire sle_pat_t pat_sel = err_hit ? err_pat
		: start_hit ? start_pat
		: f.run ? run_pat : idle_pat;

	function automatic sle_lamp_t lamp_of(sle_pat_t p, logic s, logic q, logic fl);
		sle_lamp_t l;
		l = '0;
		case (p)
			PAT_SYS_ERR: l = '{red: 1'b1, yellow: 1'b1, green: 1'b0};
			PAT_CARD_WRITE: l = '{red: 1'b1, yellow: 1'b1, green: 1'b0};
			PAT_DIAG: l = '{red: s, yellow: 1'b0, green: q};
			PAT_CFG: l = '{red: 1'b0, yellow: q, green: 1'b0};
			PAT_TEST: l = '{red: 1'b0, yellow: 1'b0, green: s};
			PAT_RUN: l = '{red: 1'b0, yellow: 1'b0, green: 1'b1};
			PAT_RUN_CARD: l = '{red: 1'b0, yellow: 1'b0, green: fl};
			PAT_RUN_WARN: l = '{red: s, yellow: 1'b0, green: 1'b1};
			PAT_RUN_WARN_CARD: l = '{red: s, yellow: 1'b0, green: fl};
			PAT_HOLD: l = '{red: 1'b1, yellow: 1'b0, green: s};
			PAT_ERR: l = '{red: 1'b1, yellow: 1'b0, green: 1'b0};
			PAT_STOP_CARD: l = '{red: 1'b0, yellow: fl, green: 1'b0};
			PAT_STOP: l = '{red: 1'b0, yellow: 1'b1, green: 1'b0};
			default: l = '0;
		endcase
		return l;
	endfunction

	wire sle_lamp_t lamp_next = lamp_of(pat_sel, blink_slow, blink_fast, flick);

	sle_lamp_t lamp_reg;
	sle_pat_t pat_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lamp_reg <= '0;
			pat_reg <= PAT_OFF;
		end else begin
			lamp_reg <= lamp_next;
			pat_reg <= pat_sel;
		end
	end

	assign lamp_red = lamp_reg.red;
	assign lamp_yellow = lamp_reg.yellow;
	assign lamp_green = {GREEN_W{lamp_reg.green}};

	// Wishbone decode; ack one cycle after the request, dropped the cycle after
	wire logic req = wb_cyc && wb_stb;
	wire logic hit = req && !ack_reg;
	wire logic sel_ctrl = (wb_adr == REG_CTRL);
	wire logic sel_status = (wb_adr == REG_STATUS);
	wire logic sel_flags = (wb_adr == REG_FLAGS);
	// Write commits on the acknowledging edge, where the master takes it
	wire logic wr_ctrl = req && ack_reg && wb_we && sel_ctrl && wb_sel[0];
	wire logic [31:0] rd_ctrl = 32'(test_reg) << CTRL_TEST_BIT;
	wire logic [31:0] rd_status = (32'(lamp_reg) << STATUS_LAMP_LSB) | (32'(pat_reg) << STATUS_PAT_LSB);
	wire logic [31:0] rd_flags = 32'(f_bits) << FLAGS_LSB;
	// Unmapped addresses still ack and read zero, so a stray access cannot hang the bus
	wire logic [31:0] rd_mux = sel_ctrl ? rd_ctrl
		: sel_status ? rd_status
		: sel_flags ? rd_flags : 32'h0000_0000;
	wire logic [31:0] dat_next = (hit && !wb_we) ? rd_mux : dat_reg;
	wire logic test_next = wr_ctrl ? wb_dat_i[CTRL_TEST_BIT] : test_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			test_reg <= CTRL_TEST_RST;
		end else begin
			ack_reg <= hit;
			dat_reg <= dat_next;
			test_reg <= test_next;
		end
	end

	assign wb_ack = ack_reg;
	assign wb_dat_o = dat_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	stop_yellow_a: assert property (pat_sel == PAT_STOP |=> lamp_yellow && !lamp_red && !lamp_reg.green)
		else $error("stop pattern did not light yellow alone");
	err_red_a: assert property (pat_sel == PAT_ERR |=> lamp_red && !lamp_yellow)
		else $error("error state did not light red");
	run_clean_a: assert property (f.run && !f.err_warn && !f.card_access && !err_hit && !start_hit
		|=> lamp_reg.green && !lamp_red && !lamp_yellow)
		else $error("clean run pattern wrong");
	run_warn_a: assert property (pat_sel == PAT_RUN_WARN
		|=> lamp_red == $past(blink_slow) && lamp_reg.green)
		else $error("run with warning pattern wrong");
	hold_point_a: assert property (pat_sel == PAT_HOLD
		|=> lamp_red && lamp_reg.green == $past(blink_slow))
		else $error("holding point pattern wrong");
	diag_blink_a: assert property (pat_sel == PAT_DIAG
		|=> lamp_red == $past(blink_slow) && lamp_reg.green == $past(blink_fast))
		else $error("start-up diagnostic pattern wrong");
	sys_err_a: assert property (f.sys_err |=> lamp_red && lamp_yellow)
		else $error("system error did not light red and yellow");
	card_write_a: assert property (f.card_write |=> lamp_red && lamp_yellow)
		else $error("card write did not light red and yellow");
	cfg_load_a: assert property (pat_sel == PAT_CFG |=> lamp_yellow == $past(blink_fast) && !lamp_red)
		else $error("configuration load pattern wrong");
	lamp_test_a: assert property (pat_sel == PAT_TEST |=> lamp_reg.green == $past(blink_slow))
		else $error("lamp test pattern wrong");
	run_card_a: assert property (pat_sel == PAT_RUN_CARD |=> lamp_reg.green == $past(flick) && !lamp_red)
		else $error("run card access pattern wrong");
	warn_card_a: assert property (pat_sel == PAT_RUN_WARN_CARD
		|=> lamp_red == $past(blink_slow) && lamp_reg.green == $past(flick))
		else $error("run warning card access pattern wrong");
	stop_card_a: assert property (pat_sel == PAT_STOP_CARD |=> lamp_yellow == $past(flick) && !lamp_red)
		else $error("stop card access pattern wrong");
	prio_order_a: assert property (err_hit && f.diag_start |-> pat_sel != PAT_DIAG ##1 lamp_yellow)
		else $error("start-up overrode an error pattern");
	ack_pulse_a: assert property (hit |=> wb_ack ##1 !wb_ack)
		else $error("wishbone ack not a single cycle pulse");
	ctrl_write_a: assert property (wr_ctrl |=> test_reg == $past(wb_dat_i[CTRL_TEST_BIT]))
		else $error("control write not stored");
endmodule

/* File: sim/sle_lamp_watch.sv */
// Operator-side lamp watcher: classifies each lamp over a 32-cycle window
`timescale 1ns/1ps
module sle_lamp_watch (
	// Clock and window control
	input wire logic clk_sys,
	input wire logic clr,
	// Lamps as {red, yellow, green[1], green[0]}
	input wire logic [3:0] lamps,
	// Codes {red, yellow, green}: 0 off, 1 on, 2 slow, 3 fast, 4 flicker, 7 odd
	output logic [11:0] codes,
	output logic split
);
	int tog[3];
	int hi[3];
	logic [2:0] prev;
	wire logic [2:0] l = {lamps[3], lamps[2], lamps[0]};
	function automatic logic [3:0] cls(input int t, input int h);
		if (t == 0)
			return (h == 32) ? 4'h1 : (h == 0) ? 4'h0 : 4'h7;
		return (t == 4) ? 4'h2 : (t == 8) ? 4'h3 : (t == 16) ? 4'h4 : 4'h7;
	endfunction
	// Toggle count tells the rate, so phase at window start does not matter
	always @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			tog[i] = clr ? 0 : tog[i] + int'(l[i] !== prev[i]);
			hi[i] = clr ? 0 : hi[i] + int'(l[i] === 1'b1);
		end
		if (clr)
			split = 1'b0;
		else if (lamps[1] !== lamps[0])
			split = 1'b1;
		prev = l;
	end
	assign codes = {cls(tog[2], hi[2]), cls(tog[1], hi[1]), cls(tog[0], hi[0])};
endmodule

/* File: sim/sle_encoder_tb.sv */
// Self-checking bench for the status lamp pattern encoder
`timescale 1ns/1ps
module sle_encoder_tb import sle_pkg::*;;
	logic clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack, clr, lamp_red, lamp_yellow, split;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [1:0] lamp_green;
	logic [11:0] codes;
	sle_flags_t core_flags;
	int num_errors = 0;
	int checks_done = 0;
	// Flags run,stop,err_state,err_warn,hold_pt,diag_start,cfg_load,sys_err,card_write,card_access
	localparam logic [21:0] ROWS [17] = '{
		{10'b0100000000, 12'h010}, {10'b0110000000, 12'h100}, {10'b1000000000, 12'h001},
		{10'b1001000000, 12'h201}, {10'b0100100000, 12'h102}, {10'b0000010000, 12'h203},
		{10'b1000010100, 12'h110}, {10'b1000000010, 12'h110}, {10'b0000010010, 12'h110},
		{10'b0000001000, 12'h030}, {10'b0000011000, 12'h203}, {10'b1000000001, 12'h004},
		{10'b1001000001, 12'h204}, {10'b0100000001, 12'h040}, {10'b0000000000, 12'h000},
		{10'b0100100001, 12'h102}, {10'b1010000000, 12'h001}};

	sle_encoder #(.HALF_SLOW(8), .HALF_FAST(4), .HALF_FLICK(2), .GREEN_W(2)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .core_flags(core_flags), .lamp_red(lamp_red),
		.lamp_yellow(lamp_yellow), .lamp_green(lamp_green), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack(wb_ack));
	sle_lamp_watch u_watch (.clk_sys(clk_sys), .clr(clr),
		.lamps({lamp_red, lamp_yellow, lamp_green}), .codes(codes), .split(split));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task conclude();
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// Settle past the 3-edge flag latency, then watch one window
	task chk_lamp(input logic [11:0] exp);
		repeat (4) @(posedge clk_sys);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		repeat (32) @(posedge clk_sys);
		@(negedge clk_sys);
		checks_done++;
		if (codes !== exp || split !== 1'b0) begin
			num_errors++;
			$display("[ERR] %0t lamps %h expected %h", $time, codes, exp);
		end
		@(posedge clk_sys);
	endtask

	// Classic single cycle; q takes read data at the acknowledging edge
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i, wb_sel} <= {2'b11, we, a, d, s};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1);
		chk_word(32'(n), 32'h2); // Ack one cycle after capture
		q = wb_dat_o;
		{wb_cyc, wb_stb} <= 2'b00;
		@(posedge clk_sys);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	initial begin
		{rst, clr, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} = '0;
		rst = 1'b1;
		core_flags = '0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 17; i++) begin
			core_flags <= ROWS[i][21:12];
			chk_lamp(ROWS[i][11:0]); // Table rows
		end
		core_flags <= 10'b1000000000;
		wb(1'b0, REG_CTRL, 32'h0, 4'hF);
		chk_word(q, 32'h0); // Control resets clear
		wb(1'b1, REG_CTRL, 32'h1, 4'h0);
		wb(1'b0, REG_CTRL, 32'h0, 4'hF);
		chk_word(q, 32'h0); // Masked write ignored
		wb(1'b1, REG_CTRL, 32'h1, 4'hF);
		wb(1'b0, REG_CTRL, 32'h0, 4'hF);
		chk_word(q, 32'h1);
		chk_lamp(12'h002); // Lamp test wins over run
		wb(1'b1, REG_STATUS, 32'h0, 4'hF);
		wb(1'b0, REG_STATUS, 32'h0, 4'hF);
		chk_word(q & 32'hF00, 32'h500); // Read-only pattern code
		wb(1'b0, REG_FLAGS, 32'h0, 4'hF);
		chk_word(q, 32'h200);
		wb(1'b0, 8'h0C, 32'h0, 4'hF);
		chk_word(q, 32'h0); // Unmapped reads zero
		wb(1'b1, REG_CTRL, 32'h0, 4'hF);
		chk_lamp(12'h001);
		core_flags <= 10'b0100000000;
		repeat (40) @(posedge clk_sys);
		rst <= 1'b1;
		@(negedge clk_sys);
		chk_word(32'({lamp_red, lamp_yellow, lamp_green, wb_ack}), 32'h0); // Async clear
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_word(32'(lamp_yellow), 32'h0); // Sync latency
		@(negedge clk_sys);
		chk_word(32'(lamp_yellow), 32'h1); // Shows at third edge
		chk_lamp(12'h010);
		conclude();
	end
endmodule
